// >>> src/rh_desc_pkg.sv
package rh_desc_pkg;
  // Register map (byte address of the descriptor word)
  localparam logic [31:0] DESC_FIRST_ADDR     = 32'h9010_1048;
  // Port power control word, commands and mask (block-local)
  localparam logic [31:0] PWR_MASK_ADDR       = 32'h9010_1080;
  localparam logic [31:0] PWR_CMD_ADDR        = 32'h9010_1084;
  localparam logic [31:0] PWR_STATUS_ADDR     = 32'h9010_1088;
  localparam logic [31:0] OC_STATUS_ADDR      = 32'h9010_108C;

  // Field positions in the descriptor word
  localparam int PGOOD_LSB    = 24;
  localparam int PGOOD_MSB    = 31;
  localparam int RSVD_LSB     = 13;
  localparam int RSVD_MSB     = 23;
  localparam int NO_OC_BIT    = 12;
  localparam int OC_MODE_BIT  = 11;
  localparam int TYPE_BIT     = 10;
  localparam int SW_MODE_BIT  = 9;
  localparam int NO_SW_BIT    = 8;
  localparam int PORT_CNT_MSB = 7;

  // Command word bit positions
  localparam int CMD_SET_GLOBAL   = 0;
  localparam int CMD_CLR_GLOBAL   = 1;
  localparam int CMD_PORT_SET_LSB = 16;
  localparam int CMD_PORT_CLR_LSB = 24;

  // Port count and limits
  localparam int          NUM_PORTS       = 4;
  localparam logic [7:0]  PORT_CNT_VALUE  = 8'h04;
  localparam logic [7:0]  PORT_CNT_MIN    = 8'h01;
  localparam logic [7:0]  PORT_CNT_MAX    = 8'h0F;

  // Reset values of the writable fields
  localparam logic [7:0]  PGOOD_RESET     = 8'h01;
  localparam logic        NO_OC_RESET     = 1'b0;
  localparam logic        SW_MODE_RESET   = 1'b1;
  localparam logic        NO_SW_RESET     = 1'b0;
  localparam logic [NUM_PORTS-1:0] MASK_RESET = 4'h0;

  // Power-good unit
  localparam int          PGOOD_UNIT_MS   = 2;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : rh_desc_pkg

// >>> src/rh_port_power.sv
module rh_port_power
  import rh_desc_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 switch_mode,
  input  wire logic                 always_on,
  input  wire logic [NUM_PORTS-1:0] per_port_power_mask,
  input  wire logic                 global_set,
  input  wire logic                 global_clr,
  input  wire logic [NUM_PORTS-1:0] port_set,
  input  wire logic [NUM_PORTS-1:0] port_clr,
  output logic      [NUM_PORTS-1:0] port_power
);
  logic [NUM_PORTS-1:0] next_power;

  always_comb begin
    next_power = port_power;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (always_on) begin
        next_power[i] = 1'b1;                                    // [RULE10]
      end else if (!switch_mode || !per_port_power_mask[i]) begin
        // Ganged mode, or unmasked port in individual mode
        if (global_set) next_power[i] = 1'b1;                    // [RULE9]
        else if (global_clr) next_power[i] = 1'b0;               // [RULE7]
      end else begin
        if (port_set[i]) next_power[i] = 1'b1;                   // [RULE8]
        else if (port_clr[i]) next_power[i] = 1'b0;              // [RULE8]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) port_power <= '0;
    else port_power <= next_power;
  end
endmodule : rh_port_power

// >>> src/root_hub_descriptor_a.sv
// How it works
// RULE1: Software waits power-good field times 2 ms after powering a port.
// RULE2: Reporting mode bit only matters while overcurrent protection is present.
// RULE3: Mode zero reports overcurrent collectively, one reports per port.
// RULE4: Reset reporting mode equals reset power switching mode.
// RULE5: Compound device type bit reads zero always, write ignored.
// RULE6: Switching mode bit matters only while power switching is enabled.
// RULE7: Switching mode zero powers ports together, one individually.
// RULE8: Masked ports in individual mode follow only per-port commands.
// RULE9: Unmasked ports in individual mode follow only global commands.
// RULE10: No-power-switch bit set keeps all ports powered.
// RULE11: Port count reads only, eight bits, between 1 and 15.
// RULE12: Bits 23 to 13 read zero and ignore writes.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module root_hub_descriptor_a
  import rh_desc_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [31:0]          s_axi_awaddr,
  input  wire logic [2:0]           s_axi_awprot,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic      [1:0]           s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [31:0]          s_axi_araddr,
  input  wire logic [2:0]           s_axi_arprot,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic      [31:0]          s_axi_rdata,
  output logic      [1:0]           s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [NUM_PORTS-1:0] port_overcurrent,
  output logic      [NUM_PORTS-1:0] port_power,
  output logic                      overcurrent_global,
  output logic      [NUM_PORTS-1:0] overcurrent_per_port
);
  logic [7:0]           power_good_delay;
  logic                 no_overcurrent_protect;
  logic                 overcurrent_report_mode;
  logic                 power_switch_mode;
  logic                 no_power_switch;
  logic [NUM_PORTS-1:0] per_port_power_mask;
  logic [31:0]          aw_addr;
  logic [31:0]          w_data;
  logic [3:0]           w_strb;
  logic                 aw_held;
  logic                 w_held;
  logic                 do_write;
  logic                 global_set;
  logic                 global_clr;
  logic [NUM_PORTS-1:0] port_set;
  logic [NUM_PORTS-1:0] port_clr;
  logic [NUM_PORTS-1:0] oc_meta;
  logic [NUM_PORTS-1:0] oc_sync;
  logic [31:0]          next_rdata;
  logic [1:0]           next_rresp;
  logic [31:0]          desc_merged;
  logic                 wr_desc;
  logic                 wr_mask;
  logic                 wr_cmd;
  logic                 aw_known;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [31:0] desc_word();
    logic [31:0] r;
    r = '0;                                                      // [RULE12]
    r[PGOOD_MSB:PGOOD_LSB] = power_good_delay;                   // [RULE1]
    r[NO_OC_BIT]           = no_overcurrent_protect;
    r[OC_MODE_BIT]         = overcurrent_report_mode;
    r[TYPE_BIT]            = 1'b0;                               // [RULE5]
    r[SW_MODE_BIT]         = power_switch_mode;
    r[NO_SW_BIT]           = no_power_switch;
    r[PORT_CNT_MSB:0]      = PORT_CNT_VALUE;                     // [RULE11]
    return r;
  endfunction : desc_word

  // Word decode only; byte lanes come from the strobes
  function automatic logic word_hit(input logic [31:0] addr,
                                    input logic [31:0] base);
    return addr[31:2] == base[31:2];
  endfunction : word_hit

  function automatic logic known_addr(input logic [31:0] addr);
    return word_hit(addr, DESC_FIRST_ADDR)
           || word_hit(addr, PWR_MASK_ADDR)
           || word_hit(addr, PWR_CMD_ADDR)
           || word_hit(addr, PWR_STATUS_ADDR)
           || word_hit(addr, OC_STATUS_ADDR);
  endfunction : known_addr

  // Write address and data are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  // A channel stays closed while its item waits or the answer is out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
                      && !s_axi_bvalid;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_desc  = do_write && word_hit(aw_addr, DESC_FIRST_ADDR);
  assign wr_mask  = do_write && word_hit(aw_addr, PWR_MASK_ADDR);
  assign wr_cmd   = do_write && word_hit(aw_addr, PWR_CMD_ADDR);
  assign aw_known = known_addr(aw_addr);

  // The answer gates do_write, so set and bready never meet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Unmapped words answer with an error and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bresp <= aw_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Reserved, type and port count are constants, so never stored
  always_comb begin
    desc_merged = merge(desc_word(), w_data, w_strb);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_good_delay <= PGOOD_RESET;
    end else if (wr_desc) begin
      power_good_delay <= desc_merged[PGOOD_MSB:PGOOD_LSB];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      no_overcurrent_protect <= NO_OC_RESET;
    end else if (wr_desc) begin
      no_overcurrent_protect <= desc_merged[NO_OC_BIT];
    end
  end

  // Reporting mode starts equal to the switching mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_report_mode <= SW_MODE_RESET;                  // [RULE4]
    end else if (wr_desc) begin
      overcurrent_report_mode <= desc_merged[OC_MODE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_switch_mode <= SW_MODE_RESET;
    end else if (wr_desc) begin
      power_switch_mode <= desc_merged[SW_MODE_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      no_power_switch <= NO_SW_RESET;
    end else if (wr_desc) begin
      no_power_switch <= desc_merged[NO_SW_BIT];
    end
  end

  // Only the low byte lane carries mask bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      per_port_power_mask <= MASK_RESET;
    end else if (wr_mask && w_strb[0]) begin
      per_port_power_mask <= w_data[NUM_PORTS-1:0];
    end
  end

  // Command strobes last one cycle; port set bits at 16+i, clear at 24+i
  always_comb begin
    global_set = wr_cmd && w_strb[0] && w_data[CMD_SET_GLOBAL];
    global_clr = wr_cmd && w_strb[0] && w_data[CMD_CLR_GLOBAL];
    port_set   = '0;
    port_clr   = '0;
    if (wr_cmd && w_strb[2]) begin
      port_set = w_data[CMD_PORT_SET_LSB +: NUM_PORTS];
    end
    if (wr_cmd && w_strb[3]) begin
      port_clr = w_data[CMD_PORT_CLR_LSB +: NUM_PORTS];
    end
  end

  // Honour the switching mode only while switching exists
  rh_port_power u_power (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .switch_mode         (power_switch_mode && !no_power_switch), // [RULE6]
    .always_on           (no_power_switch),                       // [RULE10]
    .per_port_power_mask (per_port_power_mask),
    .global_set          (global_set),
    .global_clr          (global_clr),
    .port_set            (port_set),
    .port_clr            (port_clr),
    .port_power          (port_power)
  );

  // Overcurrent pins are asynchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_meta <= '0;
      oc_sync <= '0;
    end else begin
      oc_meta <= port_overcurrent;
      oc_sync <= oc_meta;
    end
  end

  // Without protection neither overcurrent output reports, whatever the mode bit says
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_global <= 1'b0;
    end else if (no_overcurrent_protect || overcurrent_report_mode) begin
      overcurrent_global <= 1'b0;                                // [RULE2]
    end else begin
      overcurrent_global <= |oc_sync;                            // [RULE3]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overcurrent_per_port <= '0;
    end else if (no_overcurrent_protect || !overcurrent_report_mode) begin
      overcurrent_per_port <= '0;                                // [RULE2]
    end else begin
      overcurrent_per_port <= oc_sync;                           // [RULE3]
    end
  end

  always_comb begin
    next_rresp = RESP_OKAY;
    case (s_axi_araddr[31:2])
      DESC_FIRST_ADDR[31:2]: next_rdata = desc_word();
      PWR_MASK_ADDR[31:2]:   next_rdata = {28'h0, per_port_power_mask};
      PWR_CMD_ADDR[31:2]:    next_rdata = '0;
      PWR_STATUS_ADDR[31:2]: next_rdata = {28'h0, port_power};
      OC_STATUS_ADDR[31:2]:  next_rdata = {28'h0, oc_sync};
      default: begin
        next_rdata = '0;
        next_rresp = RESP_SLVERR;
      end
    endcase
  end

  // Address and answer alternate, so a read never overtakes its answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule : root_hub_descriptor_a

// >>> bench/rh_desc_monitor.sv
module rh_desc_monitor
  import rh_desc_pkg::*;
(
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic [31:0]          s_axi_araddr,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic [NUM_PORTS-1:0] port_overcurrent,
  input wire logic                 overcurrent_global,
  input wire logic [NUM_PORTS-1:0] overcurrent_per_port
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Marks a read answer that carries the descriptor word
  logic rd_desc;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_desc <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_desc <= (s_axi_araddr == DESC_FIRST_ADDR);
    end
  end
  AST_TYPE_READS_ZERO: assert property (s_axi_rvalid && rd_desc
    |-> !s_axi_rdata[10]) else $error("type bit read as one");
  AST_RSVD_READ_ZERO: assert property (s_axi_rvalid && rd_desc
    |-> s_axi_rdata[23:13] == 11'h000) else $error("reserved bits set");
  AST_PORT_COUNT: assert property (s_axi_rvalid && rd_desc
    |-> s_axi_rdata[7:0] == 8'h04) else $error("port count wrong");
  AST_OC_EXCLUSIVE: assert property (overcurrent_global
    |-> overcurrent_per_port == 4'h0) else $error("both oc modes active");
  AST_OC_QUIET: assert property ((port_overcurrent == 4'h0)[*4]
    |=> !overcurrent_global && overcurrent_per_port == 4'h0)
    else $error("oc reported with no cause");
  AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  AST_READ_RETIRE: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid) else $error("read answer not retired");
  AST_AR_REFUSED: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  AST_WRITE_ANSWER: assert property (s_axi_wvalid && s_axi_wready
    |-> ##[1:4] s_axi_bvalid) else $error("write answer late");
endmodule : rh_desc_monitor

bind root_hub_descriptor_a rh_desc_monitor mon_u (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_wready         (s_axi_wready),
  .s_axi_bvalid         (s_axi_bvalid),
  .s_axi_araddr         (s_axi_araddr),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready),
  .s_axi_rdata          (s_axi_rdata),
  .s_axi_rvalid         (s_axi_rvalid),
  .s_axi_rready         (s_axi_rready),
  .port_overcurrent     (port_overcurrent),
  .overcurrent_global   (overcurrent_global),
  .overcurrent_per_port (overcurrent_per_port)
);

// >>> bench/tb.sv
module tb
  import rh_desc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0]  s_axi_wstrb = 4'hF, port_overcurrent = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, overcurrent_global;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0]  port_power, overcurrent_per_port;
  int          err_total = 0;
  int          samples_checked = 0;

  root_hub_descriptor_a dut_u (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (s_axi_awaddr),
    .s_axi_awprot         (s_axi_awprot),
    .s_axi_awvalid        (s_axi_awvalid),
    .s_axi_awready        (s_axi_awready),
    .s_axi_wdata          (s_axi_wdata),
    .s_axi_wstrb          (s_axi_wstrb),
    .s_axi_wvalid         (s_axi_wvalid),
    .s_axi_wready         (s_axi_wready),
    .s_axi_bresp          (s_axi_bresp),
    .s_axi_bvalid         (s_axi_bvalid),
    .s_axi_bready         (s_axi_bready),
    .s_axi_araddr         (s_axi_araddr),
    .s_axi_arprot         (s_axi_arprot),
    .s_axi_arvalid        (s_axi_arvalid),
    .s_axi_arready        (s_axi_arready),
    .s_axi_rdata          (s_axi_rdata),
    .s_axi_rresp          (s_axi_rresp),
    .s_axi_rvalid         (s_axi_rvalid),
    .s_axi_rready         (s_axi_rready),
    .port_overcurrent     (port_overcurrent),
    .port_power           (port_power),
    .overcurrent_global   (overcurrent_global),
    .overcurrent_per_port (overcurrent_per_port)
  );

  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic tally_and_finish();
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Bounded waits only; a stuck slave ends the run
  task automatic guard(input int n);
    if (n >= 60) begin
      err_total++;
      tally_and_finish();
    end
  endtask : guard

  task automatic axi_write(input logic [31:0] a, d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 60);
    guard(n);
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask : axi_write

  task automatic axi_read(input logic [31:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 60);
    guard(n);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    resp = s_axi_rresp;
  endtask : axi_read

  task automatic desc_check(input logic [31:0] exp, input string what);
    axi_read(DESC_FIRST_ADDR);
    check(what, rd, exp);
    check("read resp", resp, RESP_OKAY);
  endtask : desc_check

  task automatic field_access();
    axi_write(DESC_FIRST_ADDR, 32'hFFFF_FFFF);
    desc_check(32'hFF00_1B04, "desc ones");
    axi_write(DESC_FIRST_ADDR, 32'h0000_0000);
    desc_check(32'h0000_0004, "desc zeros");
    axi_write(32'h9010_1090, 32'hFFFF_FFFF);
    check("bad write resp", resp, RESP_SLVERR);
    axi_read(32'h9010_1090);
    check("bad read resp", resp, RESP_SLVERR);
    desc_check(32'h0000_0004, "desc kept");
  endtask : field_access

  task automatic power_cmd(input logic [31:0] cmd, input logic [3:0] exp);
    axi_write(PWR_CMD_ADDR, cmd);
    axi_read(PWR_STATUS_ADDR);
    check("port power", port_power, exp);
    check("power status", rd, {28'h0, exp});
  endtask : power_cmd

  task automatic individual_power();
    // Ports were left powered by the always-on setting; clear them first
    power_cmd(32'h0000_0002, 4'h0);
    axi_write(DESC_FIRST_ADDR, 32'h0100_0A00);
    axi_write(PWR_MASK_ADDR, 32'h0000_0003);
    power_cmd(32'h0000_0001, 4'hC);
    power_cmd(32'h0001_0000, 4'hD);
    power_cmd(32'h0000_0002, 4'h1);
    power_cmd(32'h0100_0000, 4'h0);
    power_cmd(32'h0004_0000, 4'h0);
  endtask : individual_power

  task automatic ganged_power();
    axi_write(DESC_FIRST_ADDR, 32'h0100_0000);
    power_cmd(32'h0000_0001, 4'hF);
    power_cmd(32'h0000_0002, 4'h0);
    axi_write(DESC_FIRST_ADDR, 32'h0100_0300);
    power_cmd(32'h0000_0002, 4'hF);
  endtask : ganged_power

  task automatic oc_mode(input logic [31:0] desc, input logic g,
                         input logic [3:0] pp);
    axi_write(DESC_FIRST_ADDR, desc);
    axi_read(OC_STATUS_ADDR);
    check("oc global", overcurrent_global, g);
    check("oc per port", overcurrent_per_port, pp);
    check("oc status", rd, {28'h0, port_overcurrent});
  endtask : oc_mode

  task automatic overcurrent();
    port_overcurrent <= 4'h4;
    oc_mode(32'h0100_0200, 1'b1, 4'h0);
    oc_mode(32'h0100_0A00, 1'b0, 4'h4);
    oc_mode(32'h0100_1A00, 1'b0, 4'h0);
    oc_mode(32'h0100_1200, 1'b0, 4'h0);
    port_overcurrent <= 4'h0;
  endtask : overcurrent

  // Ports are still powered here, so the reset has something to undo
  task automatic mid_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    check("power after reset", port_power, 4'h0);
    desc_check(32'h0100_0A04, "desc re-reset");
  endtask : mid_reset

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    desc_check(32'h0100_0A04, "desc reset");
    field_access();
    individual_power();
    ganged_power();
    overcurrent();
    mid_reset();
    tally_and_finish();
  end
endmodule : tb
